// ===== hw/adc_ctrl.sv
// converter sequencer with stop-mode handling, APB register file and compare
// assumes the analog core returns a sample via a one-cycle valid; stop inputs are synchronous levels
// Notes on behaviour
// - stop3 without async clock aborts to idle
// - stop3 never touches result registers
// - after stop3 wait for new trigger
// - async clock: running conversion completes in stop3
// - async clock: triggers and continuous start in stop3
// - completion sets flag, interrupt if enabled
// - stop1/stop2 disable and reset all registers
// - config bits: low power, divider, sample
// - config bits: resolution and clock source
// - trigger register: active, trigger, compare bits
// - trigger bits 3:0 read zero
// - channel register: done, irq, continuous
// - low five bits select channel
// - compare value held for compare
// - pin control bits disable digital input
// - ten-bit read lock blocks new result
// - channel write restarts unless all ones, which lets a running conversion finish
// - compare direction chooses ge or lt
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hw_trigger,
    input  wire logic        stop3_req,
    input  wire logic        stop12_req,
    input  wire sample_t     analog_sample,
    output logic             conv_start,
    output logic      [4:0]  channel_out,
    output logic             done_irq,
    output logic      [15:0] pin_digital_disable
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  cfg_reg, trig_reg, ch_reg, cmph_reg, cmpl_reg, apc1_reg, apc2_reg;
    logic [7:0]  resh_reg, resl_reg;
    logic        done_reg, lock_reg, stop3_d_reg, hw_s1_reg, hw_s2_reg, hw_d_reg;
    logic [5:0]  cnt_reg;
    logic [1:0]  div_reg;
    conv_state_t state_reg;
    logic        wr, rd, wr_ch, wr_mode, abort, start, finish, cmp_ok, hw_edge, async_clk, tick;
    logic [9:0]  cmp_val, diff;

    function automatic logic [5:0] conv_len(input logic [7:0] cfg);
        logic [5:0] n;
        n = cfg[CFG_LSMP_BIT] ? CONV_LONG_CYC : CONV_SHORT_CYC;
        if (cfg[CFG_RES_LSB +: 2] == RES_10BIT) n = n + CONV_10B_EXTRA;
        return n;
    endfunction

    assign wr       = psel && penable && pwrite;
    assign rd       = psel && penable && !pwrite;
    assign wr_ch    = wr && paddr == CHMODE_OFF;
    assign wr_mode  = wr && (paddr == CFG_OFF || paddr == TRIG_OFF || paddr == CMPH_OFF || paddr == CMPL_OFF);
    assign async_clk = cfg_reg[1:0] == CLK_ASYNC;
    assign hw_edge  = hw_s2_reg && !hw_d_reg;
    assign tick     = div_reg == 2'h0;
    assign cmp_val  = {cmph_reg[1:0], cmpl_reg};
    assign diff     = analog_sample.value - cmp_val;
    // ge when upper select set, lt otherwise
    assign cmp_ok   = !trig_reg[TRIG_CMPEN_BIT] ||
                      (trig_reg[TRIG_CMPGT_BIT] ? analog_sample.value >= cmp_val
                                                : analog_sample.value <  cmp_val);
    // entering stop3 on the bus clock kills the conversion
    assign abort    = wr_mode || (stop3_req && !stop3_d_reg && !async_clk);
    assign start    = (wr_ch && pwdata[4:0] != CH_OFF_CODE)
                   || (state_reg == ST_IDLE && !abort && ch_reg[4:0] != CH_OFF_CODE &&
                       trig_reg[TRIG_HW_BIT] && hw_edge);
    assign finish   = state_reg == ST_DONE && analog_sample.valid;

    ////////////////////////////////////////////////////////////////////////
    // hardware trigger comes from another block's pin domain, so two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_s1_reg <= 1'b0;
            hw_s2_reg <= 1'b0;
            hw_d_reg  <= 1'b0;
            stop3_d_reg <= 1'b0;
        end else begin
            hw_s1_reg <= hw_trigger;
            hw_s2_reg <= hw_s1_reg;
            hw_d_reg  <= hw_s2_reg;
            stop3_d_reg <= stop3_req;
        end
    end

    // configuration registers; stop1/stop2 forces all to reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RST; trig_reg <= TRIG_RST; ch_reg <= CHMODE_RST;
            cmph_reg <= 8'h00; cmpl_reg <= 8'h00; apc1_reg <= 8'h00; apc2_reg <= 8'h00;
        end else if (stop12_req) begin
            cfg_reg <= CFG_RST; trig_reg <= TRIG_RST; ch_reg <= CHMODE_RST;
            cmph_reg <= 8'h00; cmpl_reg <= 8'h00; apc1_reg <= 8'h00; apc2_reg <= 8'h00;
        end else if (wr) begin
            case (paddr)
                CFG_OFF:    cfg_reg <= pwdata[7:0];
                TRIG_OFF:   trig_reg <= pwdata[7:0] & TRIG_WMASK;
                CHMODE_OFF: ch_reg <= pwdata[7:0] & CH_WMASK;
                CMPH_OFF:   cmph_reg <= {6'h00, pwdata[1:0]};
                CMPL_OFF:   cmpl_reg <= pwdata[7:0];
                APC1_OFF:   apc1_reg <= pwdata[7:0];
                APC2_OFF:   apc2_reg <= pwdata[7:0];
                default:    ;
            endcase
        end
    end

    // sequencer: sample phase counted on the divided conversion clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE; cnt_reg <= 6'd0; div_reg <= 2'h0;
        end else if (stop12_req || abort) begin
            state_reg <= ST_IDLE; cnt_reg <= 6'd0; div_reg <= 2'h0;
        end else if (start) begin
            state_reg <= ST_CONV; cnt_reg <= conv_len(cfg_reg); div_reg <= cfg_reg[6:5];
        end else begin
            case (state_reg)
                ST_CONV: begin
                    div_reg <= tick ? cfg_reg[6:5] : div_reg - 2'h1;
                    if (tick) cnt_reg <= cnt_reg - 6'd1;
                    if (tick && cnt_reg == 6'd1) state_reg <= ST_DONE;
                end
                ST_DONE: if (analog_sample.valid) begin
                    // continuous restarts; single restarts only if its result was blocked by the lock with compare met, else ends
                    if ((ch_reg[CH_CONT_BIT] || (lock_reg && cmp_ok)) && ch_reg[4:0] != CH_OFF_CODE) begin
                        state_reg <= ST_CONV; cnt_reg <= conv_len(cfg_reg); div_reg <= cfg_reg[6:5];
                    end else state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // results, read lock and done flag; stop3 does not disturb results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resh_reg <= 8'h00; resl_reg <= 8'h00; done_reg <= 1'b0; lock_reg <= 1'b0;
        end else if (stop12_req) begin
            resh_reg <= 8'h00; resl_reg <= 8'h00; done_reg <= 1'b0; lock_reg <= 1'b0;
        end else begin
            if (rd && paddr == RESH_OFF && cfg_reg[3:2] == RES_10BIT) lock_reg <= 1'b1;
            if (rd && paddr == RESL_OFF) lock_reg <= 1'b0;
            if (wr_ch || wr_mode || (rd && paddr == RESL_OFF)) done_reg <= 1'b0;
            // set beats clear in the same cycle
            if (finish && cmp_ok && !lock_reg) begin
                done_reg <= 1'b1;
                if (trig_reg[TRIG_CMPEN_BIT]) {resh_reg, resl_reg} <= {6'h00, diff};
                else if (cfg_reg[3:2] == RES_10BIT)
                    {resh_reg, resl_reg} <= {6'h00, analog_sample.value};
                else {resh_reg, resl_reg} <= {8'h00, analog_sample.value[9:2]};
            end
        end
    end

    // bus side answers with zero wait states; unmapped reads zero with error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && !penable) begin
                case (paddr)
                    CFG_OFF:    prdata <= {24'h0, cfg_reg};
                    TRIG_OFF:   prdata <= {24'h0, state_reg != ST_IDLE, trig_reg[6:4], 4'h0};
                    CHMODE_OFF: prdata <= {24'h0, done_reg, ch_reg[6:0]};
                    RESH_OFF:   prdata <= {24'h0, resh_reg};
                    RESL_OFF:   prdata <= {24'h0, resl_reg};
                    CMPH_OFF:   prdata <= {24'h0, cmph_reg};
                    CMPL_OFF:   prdata <= {24'h0, cmpl_reg};
                    APC1_OFF:   prdata <= {24'h0, apc1_reg};
                    APC2_OFF:   prdata <= {24'h0, apc2_reg};
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    // outputs to analog core and interrupt controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0; channel_out <= CH_OFF_CODE; done_irq <= 1'b0; pin_digital_disable <= 16'h0;
        end else begin
            conv_start  <= start;
            channel_out <= ch_reg[4:0];
            done_irq    <= done_reg && ch_reg[CH_IEN_BIT];
            pin_digital_disable <= {apc2_reg, apc1_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_STOP3_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        (stop3_req && !stop3_d_reg && !async_clk && !stop12_req) |=> state_reg == ST_IDLE)
        else $error("stop3 did not abort");
    AST_STOP3_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        (stop3_req && !finish && !stop12_req) |=> $stable({resh_reg, resl_reg}))
        else $error("result changed in stop3");
    AST_ASYNC_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        (async_clk && state_reg == ST_CONV && !wr && !stop12_req) |=> state_reg != ST_IDLE)
        else $error("async conversion dropped");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (done_reg && ch_reg[CH_IEN_BIT]) |=> done_irq)
        else $error("irq missing");
    AST_STOP12: assert property (@(posedge pclk) disable iff (!presetn)
        stop12_req |=> (cfg_reg == CFG_RST && ch_reg == CHMODE_RST && !done_reg))
        else $error("stop1/2 reset missing");
    AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (finish && lock_reg && !rd) |=> $stable(resl_reg))
        else $error("locked result overwritten");
    AST_CHWR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ch && pwdata[4:0] != CH_OFF_CODE && !stop12_req && !abort) |=> (state_reg == ST_CONV && conv_start))
        else $error("channel write no restart");
    AST_TRIGRD: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> (paddr != TRIG_OFF || prdata[3:0] == 4'h0))
        else $error("trigger low bits nonzero");
    COV_DONE:  cover property (@(posedge pclk) disable iff (!presetn) finish && cmp_ok);
    COV_STOP3: cover property (@(posedge pclk) disable iff (!presetn) stop3_req && state_reg == ST_CONV);
    COV_BLOCK: cover property (@(posedge pclk) disable iff (!presetn) finish && lock_reg);
endmodule // adc_ctrl

// ===== hw/adc_ctrl_pkg.sv
// package for the converter control block: register map, field positions, reset values, timing
// assumes an APB slave with 32-bit data; registers take one aligned word each
package adc_ctrl_pkg;
    localparam logic [11:0] CFG_OFF    = 12'h000;
    localparam logic [11:0] TRIG_OFF   = 12'h004;
    localparam logic [11:0] CHMODE_OFF = 12'h008;
    localparam logic [11:0] RESH_OFF   = 12'h00c;
    localparam logic [11:0] RESL_OFF   = 12'h010;
    localparam logic [11:0] CMPH_OFF   = 12'h014;
    localparam logic [11:0] CMPL_OFF   = 12'h018;
    localparam logic [11:0] APC1_OFF   = 12'h01c;
    localparam logic [11:0] APC2_OFF   = 12'h020;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [7:0]  TRIG_RST   = 8'h00;
    localparam logic [7:0]  CHMODE_RST = 8'h1f;
    localparam logic [4:0]  CH_OFF_CODE = 5'h1f;
    localparam logic [1:0]  RES_10BIT  = 2'h2;
    localparam logic [1:0]  CLK_ASYNC  = 2'h3;
    localparam int CFG_LP_BIT = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP_BIT = 4;
    localparam int CFG_RES_LSB = 2;
    localparam int TRIG_ACT_BIT = 7;
    localparam int TRIG_HW_BIT = 6;
    localparam int TRIG_CMPEN_BIT = 5;
    localparam int TRIG_CMPGT_BIT = 4;
    localparam logic [7:0] TRIG_WMASK = 8'h70;
    localparam int CH_DONE_BIT = 7;
    localparam int CH_IEN_BIT = 6;
    localparam int CH_CONT_BIT = 5;
    localparam logic [7:0] CH_WMASK = 8'h7f;
    // conversion length in conversion clock cycles
    localparam logic [5:0] CONV_SHORT_CYC = 6'd20;
    localparam logic [5:0] CONV_LONG_CYC  = 6'd40;
    localparam logic [5:0] CONV_10B_EXTRA = 6'd3;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} conv_state_t;
    typedef struct packed {
        logic [9:0] value;
        logic       valid;
    } sample_t;
endpackage

// ===== test/adc_ctrl_tb.sv
// self-checking bench for the converter control block: apb register access, conversions, stop modes
// assumes a wait-free apb slave and an analog core answered here by one-cycle sample pulses
module adc_ctrl_tb
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        hw_trigger, stop3_req, stop12_req, conv_start, done_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  channel_out;
    logic [15:0] pin_digital_disable;
    sample_t     analog_sample;
    int          n_errors = 0;
    int          checks_done = 0;
    adc_ctrl u_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_trigger(hw_trigger), .stop3_req(stop3_req), .stop12_req(stop12_req),
        .analog_sample(analog_sample), .conv_start(conv_start), .channel_out(channel_out),
        .done_irq(done_irq), .pin_digital_disable(pin_digital_disable));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    // analog core answers with a pulse every other cycle; extra pulses outside its done phase are ignored
    task automatic feed(input logic [9:0] v, input int lim);
        for (int i = 0; i < lim && done_irq !== 1'b1; i++) begin
            analog_sample <= '{v, 1'b1};
            @(posedge pclk);
            analog_sample <= '{v, 1'b0};
            @(posedge pclk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rdchk(CFG_OFF, {24'h0, CFG_RST});
        rdchk(TRIG_OFF, {24'h0, TRIG_RST});
        rdchk(CHMODE_OFF, {24'h0, CHMODE_RST});
        chk({27'h0, channel_out}, 32'h0000_001f);
        apb(1'b0, 12'h100, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_init();
        wr(CFG_OFF, 32'h98);
        wr(TRIG_OFF, 32'h00);
        wr(CHMODE_OFF, 32'h41);
        @(posedge pclk);
        chk({27'h0, channel_out}, 32'h0000_0001);
        feed(10'h2a5, 100);
        chk({31'h0, done_irq}, 32'h1);
        rdchk(CHMODE_OFF, 32'hc1);
        rdchk(RESH_OFF, 32'h02);
        rdchk(RESL_OFF, 32'ha5);
        rdchk(CHMODE_OFF, 32'h41);
        $display("test init done");
    endtask
    task automatic t_trig();
        wr(TRIG_OFF, 32'hfc);
        rdchk(TRIG_OFF, 32'h70);
        wr(TRIG_OFF, 32'h00);
        $display("test trigger register done");
    endtask
    task automatic t_stop3_bus();
        wr(CFG_OFF, 32'h18);
        wr(CHMODE_OFF, 32'h45);
        repeat (5) @(posedge pclk);
        rdchk(TRIG_OFF, 32'h80);
        stop3_req <= 1'b1;
        repeat (4) @(posedge pclk);
        feed(10'h111, 60);
        stop3_req <= 1'b0;
        feed(10'h111, 60);
        chk({31'h0, done_irq}, 32'h0);
        rdchk(TRIG_OFF, 32'h00);
        rdchk(RESH_OFF, 32'h02);
        rdchk(RESL_OFF, 32'ha5);
        $display("test stop3 bus clock done");
    endtask
    task automatic t_stop3_async();
        int n;
        wr(CFG_OFF, 32'h03);
        wr(TRIG_OFF, 32'h40);
        // low byte read leaves no blocking pending before stop3
        rdchk(RESL_OFF, 32'ha5);
        wr(CHMODE_OFF, 32'h42);
        stop3_req <= 1'b1;
        feed(10'h0c3, 100);
        chk({31'h0, done_irq}, 32'h1);
        rdchk(RESL_OFF, 32'h30);
        hw_trigger <= 1'b1;
        n = 0;
        while (conv_start !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, conv_start}, 32'h1);
        chk({27'h0, channel_out}, 32'h0000_0002);
        feed(10'h0c3, 100);
        chk({31'h0, done_irq}, 32'h1);
        hw_trigger <= 1'b0;
        stop3_req <= 1'b0;
        @(posedge pclk);
        $display("test stop3 async clock done");
    endtask
    task automatic t_cmp();
        wr(CFG_OFF, 32'h00);
        wr(TRIG_OFF, 32'h30);
        wr(CMPH_OFF, 32'h00);
        wr(CMPL_OFF, 32'h10);
        wr(CHMODE_OFF, 32'h43);
        feed(10'h100, 100);
        chk({31'h0, done_irq}, 32'h1);
        rdchk(RESL_OFF, 32'hf0);
        wr(TRIG_OFF, 32'h20);
        wr(CHMODE_OFF, 32'h43);
        feed(10'h100, 40);
        chk({31'h0, done_irq}, 32'h0);
        wr(TRIG_OFF, 32'h00);
        $display("test compare done");
    endtask
    task automatic t_stop12();
        wr(APC1_OFF, 32'h02);
        @(posedge pclk);
        chk({16'h0, pin_digital_disable}, 32'h0000_0002);
        stop12_req <= 1'b1;
        repeat (2) @(posedge pclk);
        stop12_req <= 1'b0;
        @(posedge pclk);
        rdchk(CFG_OFF, {24'h0, CFG_RST});
        rdchk(CHMODE_OFF, {24'h0, CHMODE_RST});
        chk({16'h0, pin_digital_disable}, 32'h0);
        chk({31'h0, done_irq}, 32'h0);
        wr(CFG_OFF, 32'h98);
        rdchk(CFG_OFF, 32'h98);
        $display("test stop1 stop2 done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        hw_trigger = 1'b0; stop3_req = 1'b0; stop12_req = 1'b0; analog_sample = '{10'h000, 1'b0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_init();
        t_trig();
        t_stop3_bus();
        t_stop3_async();
        t_cmp();
        t_stop12();
        end_of_test();
    end
endmodule // adc_ctrl_tb
